// File: logic/dami_dev.sv
`timescale 1ns/100ps
// Purpose: Converter end: startup sequencing, mode choice, register port
// Assumes: Link signals synchronous to hclk; master clock is hclk
// Notes: Analog path is out of scope; reference_output is a digital enable
module dami_dev
    import dami_pkg::*;
#(
    parameter int STARTUP_CYCLES = dami_pkg::STARTUP_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    dami_if.dev lnk,
    // User side status
    output logic reference_output,
    output logic port_mode,
    output logic running,
    output dami_pkg::dami_speed_e speed_mode_field,
    output logic [2:0] interface_format_field,
    output logic deemphasis_select,
    output logic slow_filter,
    output logic ratio_ok,
    output logic signed [23:0] sample_out,
    output logic sample_valid
);
    dami_state_e st_r;
    dami_state_e st_nxt;
    logic [7:0] pwr_r;
    logic [7:0] reference_output_r;
    logic [7:0] cfg_r;
    logic [7:0] rdata_r;
    logic ack_r;
    logic port_r;
    logic [3:0] strap_r;
    logic [25:0] tmr_r;
    logic [25:0] tmr_nxt;
    logic bck_d_r;
    logic frm_d_r;
    logic [23:0] shift_r;
    logic ratio_ok_w;
    // Registers restart at defaults whenever link reset is low
    wire rst_all = !hresetn || !lnk.link_rst_n;
    wire win_open = (tmr_r < 26'(STARTUP_CYCLES));
    wire wr_pwr = lnk.reg_wr && lnk.reg_addr == REG_PWR;
    wire wr_reference_output = lnk.reg_wr && lnk.reg_addr == REG_REFERENCE_OUTPUT;
    wire wr_cfg = lnk.reg_wr && lnk.reg_addr == REG_CFG;
    wire port_hit = wr_pwr && lnk.reg_wdata == PORT_EN_VAL;
    wire power_down_bit = port_r ? pwr_r[PWR_PDN_BIT] : 1'b0;
    wire [2:0] sa_fmt = {1'b0, strap_r[1:0]};
    wire sa_bits = lnk.bitstream_select_pin;
    // Select pin overrides the straps; pin 2 alone keeps single speed with de-emphasis
    wire [1:0] sa_spd = sa_bits ? DAMI_SPD_BITS :
                        strap_r[3] ? (strap_r[2] ? 2'h2 : 2'h1) : 2'h0;
    wire [1:0] spd_w = port_r ? cfg_r[CFG_SPD_LSB +: 2] : sa_spd;
    wire [2:0] fmt_w = port_r ? cfg_r[CFG_FMT_LSB +: 3] : sa_fmt;
    wire dem_req = port_r ? cfg_r[CFG_DEM_BIT] : (!strap_r[3] && strap_r[2]);
    wire bck_rise = lnk.bit_clock && !bck_d_r;
    wire frm_edge = lnk.frame_clock != frm_d_r;
    wire [4:0] fmt_bits = (fmt_w == 3'h2) ? 5'h10 : (fmt_w == 3'h4) ? 5'h14 :
                          (fmt_w == 3'h5) ? 5'h12 : 5'h18;
    wire [4:0] pad_bits = 5'h18 - fmt_bits;
    // Reference stays low through reset and the low-power wait
    wire powered = !rst_all && st_r != DAMI_ST_WAIT && st_r != DAMI_ST_RESET;

    assign tmr_nxt = (tmr_r == 26'h3FFFFFF) ? tmr_r : tmr_r + 26'h0000001;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            DAMI_ST_RESET: st_nxt = DAMI_ST_WAIT;
            // Hold low power until the startup window closes and power-down is clear
            DAMI_ST_WAIT: if (!win_open && !power_down_bit) st_nxt = DAMI_ST_PWRUP;
            DAMI_ST_PWRUP: if (tmr_r >= 26'(PWRUP_CYC)) st_nxt = DAMI_ST_RUN;
            // Setting power-down again drops back to the low-power wait
            DAMI_ST_RUN: if (power_down_bit) st_nxt = DAMI_ST_WAIT;
            default: st_nxt = DAMI_ST_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= DAMI_ST_RESET;
            tmr_r <= 26'h0000000;
        end else if (!lnk.link_rst_n) begin
            // Link reset acts as the converter's own reset pin
            st_r <= DAMI_ST_RESET;
            tmr_r <= 26'h0000000;
        end else begin
            st_r <= st_nxt;
            // Timer restarts at power-up; win_open is then true again until STARTUP_CYCLES have passed
            tmr_r <= (st_r == DAMI_ST_WAIT && st_nxt == DAMI_ST_PWRUP) ?
                     26'h0000000 : tmr_nxt;
        end
    end

    // Register port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_r <= PWR_RST;
            reference_output_r <= REFERENCE_OUTPUT_RST;
            cfg_r <= CFG_RST;
            port_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (rst_all) begin
            pwr_r <= PWR_RST;
            reference_output_r <= REFERENCE_OUTPUT_RST;
            cfg_r <= CFG_RST;
            port_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= lnk.reg_wr || lnk.reg_rd;
            if (wr_pwr) pwr_r <= lnk.reg_wdata;
            if (wr_reference_output) reference_output_r <= lnk.reg_wdata;
            if (wr_cfg) cfg_r <= lnk.reg_wdata;
            // Enable accepted inside the window, or at any later time
            if (port_hit || (wr_pwr && lnk.reg_wdata[PWR_PORT_ENABLE_BIT_BIT])) begin
                port_r <= 1'b1;
            end
            if (lnk.reg_rd) begin
                if (lnk.reg_addr == REG_PWR) rdata_r <= pwr_r;
                else if (lnk.reg_addr == REG_REFERENCE_OUTPUT) rdata_r <= reference_output_r;
                else if (lnk.reg_addr == REG_CFG) rdata_r <= cfg_r;
                else rdata_r <= 8'h00;
            end
        end
    end
    assign lnk.reg_rdata = rdata_r;
    assign lnk.reg_ack = ack_r;

    // Straps caught once when the window closes without port enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_r <= 4'h0;
        end else if (!lnk.link_rst_n) begin
            // A link reset is a device reset, so old straps are dropped
            strap_r <= 4'h0;
        end else if (st_r == DAMI_ST_WAIT && tmr_r == 26'(STARTUP_CYCLES) && !port_r) begin
            strap_r <= lnk.strap_pins;
        end
    end

    dami_ratio_chk u_ratio (
        .hclk(hclk),
        .hresetn(hresetn),
        .frame_clock(lnk.frame_clock),
        .speed(dami_speed_e'(spd_w)),
        .high_ok(port_r && pwr_r[PWR_DIV_BIT]),
        .ratio_ok_r(ratio_ok_w)
    );

    // Serial capture, MSB first, last fmt_bits before frame edge kept
    // Words longer than 24 bits lose their top bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bck_d_r <= 1'b0;
            frm_d_r <= 1'b0;
            shift_r <= 24'h000000;
            sample_out <= 24'h000000;
            sample_valid <= 1'b0;
        end else begin
            bck_d_r <= lnk.bit_clock;
            frm_d_r <= lnk.frame_clock;
            sample_valid <= 1'b0;
            if (frm_edge && st_r == DAMI_ST_RUN && spd_w != DAMI_SPD_BITS) begin
                // Two's complement: sign-extend from the format width
                sample_out <= $signed(shift_r << pad_bits) >>> pad_bits;
                sample_valid <= 1'b1;
            end else if (bck_rise) begin
                shift_r <= {shift_r[22:0], lnk.audio_data_in};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reference_output <= 1'b0;
            port_mode <= 1'b0;
            running <= 1'b0;
            speed_mode_field <= DAMI_SPD_SINGLE;
            interface_format_field <= 3'h0;
            deemphasis_select <= 1'b0;
            slow_filter <= 1'b0;
            ratio_ok <= 1'b0;
        end else begin
            reference_output <= powered;
            port_mode <= port_r;
            running <= st_r == DAMI_ST_RUN;
            // Speed sets the oversampling: 128x, 64x, 32x
            speed_mode_field <= dami_speed_e'(spd_w);
            interface_format_field <= fmt_w;
            deemphasis_select <= dem_req && spd_w == DAMI_SPD_SINGLE;
            // Stand-alone gives no way to ask for the slow filter
            slow_filter <= port_r && reference_output_r[REFERENCE_OUTPUT_SLOW_BIT];
            ratio_ok <= ratio_ok_w;
        end
    end
endmodule

// File: logic/dami_pkg.sv
// Purpose: Shared constants and types for the audio input mode control link
// Assumes: 50 MHz hclk; control registers reached over the link's register port
// Notes: Times are kept in their own unit, cycle counts derive from them
package dami_pkg;
    localparam int CLK_MHZ = 50;
    localparam int STARTUP_MS = 10;
    localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
    localparam int PWRUP_US = 10;
    localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
    localparam logic [7:0] REG_PWR = 8'h05;
    localparam logic [7:0] REG_REFERENCE_OUTPUT = 8'h06;
    localparam logic [7:0] REG_CFG = 8'h02;
    localparam logic [7:0] PORT_EN_VAL = 8'h30;
    localparam int PWR_PDN_BIT = 0;
    localparam int PWR_PORT_ENABLE_BIT_BIT = 7;
    localparam int PWR_DIV_BIT = 1;
    localparam int REFERENCE_OUTPUT_SLOW_BIT = 5;
    localparam logic [7:0] PWR_RST = 8'h01;
    localparam logic [7:0] REFERENCE_OUTPUT_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam int CFG_FMT_LSB = 4;
    localparam int CFG_SPD_LSB = 0;
    localparam int CFG_DEM_BIT = 2;
    // Bus register offsets (chosen)
    localparam logic [7:0] AHB_CMD = 8'h00;
    localparam logic [7:0] AHB_STAT = 8'h04;
    localparam logic [7:0] AHB_PIN = 8'h08;
    localparam int CMD_GO_BIT = 31;
    localparam int CMD_WR_BIT = 30;

    typedef enum logic [1:0] {
        DAMI_SPD_SINGLE = 2'h0,
        DAMI_SPD_DOUBLE = 2'h1,
        DAMI_SPD_QUAD = 2'h2,
        DAMI_SPD_BITS = 2'h3
    } dami_speed_e;

    typedef enum logic [3:0] {
        DAMI_ST_RESET = 4'h1,
        DAMI_ST_WAIT = 4'h2,
        DAMI_ST_PWRUP = 4'h4,
        DAMI_ST_RUN = 4'h8
    } dami_state_e;
endpackage

// File: logic/dami_if.sv
`timescale 1ns/100ps
// Purpose: Link between the audio source/host end and the converter end
// Assumes: One clock shared by both ends
// Notes: Register port is a one-cycle write/read strobe
interface dami_if;
    logic link_rst_n;
    logic [3:0] strap_pins;
    logic bitstream_select_pin;
    logic frame_clock;
    logic bit_clock;
    logic audio_data_in;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    modport dev (input link_rst_n, strap_pins, bitstream_select_pin, frame_clock,
        bit_clock, audio_data_in, reg_wr, reg_rd, reg_addr, reg_wdata,
        output reg_rdata, reg_ack);
    modport src (output link_rst_n, strap_pins, bitstream_select_pin, frame_clock,
        bit_clock, audio_data_in, reg_wr, reg_rd, reg_addr, reg_wdata,
        input reg_rdata, reg_ack);
endinterface

// File: logic/dami_ratio_chk.sv
`timescale 1ns/100ps
// Purpose: Measures master clock cycles per frame and checks the ratio
// Assumes: Frame clock sampled synchronously; hclk stands in for master clock
// Notes: Phase of frame to master clock is free, only period counts
module dami_ratio_chk
    import dami_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Inputs
    input wire logic frame_clock,
    input wire dami_pkg::dami_speed_e speed,
    input wire logic high_ok,
    // Result
    output logic ratio_ok_r
);
    logic frame_d_r;
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    wire rise = frame_clock & ~frame_d_r;

    function automatic logic ratio_legal(input logic [11:0] n, input dami_speed_e s,
                                         input logic hi);
        case (s)
            DAMI_SPD_SINGLE: ratio_legal = (n == 12'h100) || (n == 12'h180) ||
                (n == 12'h200) || (n == 12'h300) || (hi && n == 12'h400);
            DAMI_SPD_DOUBLE: ratio_legal = (n == 12'h080) || (n == 12'h0C0) ||
                (n == 12'h100) || (n == 12'h180) || (hi && n == 12'h200);
            DAMI_SPD_QUAD: ratio_legal = (n == 12'h040) || (n == 12'h060) ||
                (n == 12'h080) || (n == 12'h0C0) || (hi && n == 12'h100);
            default: ratio_legal = 1'b1;
        endcase
    endfunction

    // Saturate so a stopped frame clock never wraps into a legal count
    assign cnt_nxt = rise ? 12'h001 : ((cnt_r == 12'hFFF) ? cnt_r : cnt_r + 12'h001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_d_r <= 1'b0;
            cnt_r <= 12'h000;
            ratio_ok_r <= 1'b0;
        end else begin
            frame_d_r <= frame_clock;
            cnt_r <= cnt_nxt;
            if (rise) begin
                ratio_ok_r <= ratio_legal(cnt_r, speed, high_ok);
            end
        end
    end
endmodule

// File: logic/dami_src.sv
`timescale 1ns/100ps
// Purpose: Source and host end: drives link from AHB-Lite commands
// Assumes: Software writes pin levels and register commands over AHB-Lite
// Notes: Zero-wait slave; register command completes on device ack
module dami_src
    import dami_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link
    dami_if.src lnk
);
    logic [8:0] pin_r;
    logic [8:0] pin_nxt;
    logic busy_r;
    logic wr_r;
    logic rd_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] rdat_r;
    logic [31:0] hrdata_nxt;
    logic aph_wr_r;
    logic [7:0] aph_addr_r;
    wire aph = hsel && htrans[1];
    wire dph_cmd = aph_wr_r && aph_addr_r == AHB_CMD;
    wire dph_pin = aph_wr_r && aph_addr_r == AHB_PIN;
    wire go = dph_cmd && hwdata[CMD_GO_BIT] && !busy_r;

    // Pin word: 0 reset_n, 1 select, 2 frame, 3 bit clock, 4 data, 8:5 straps
    assign pin_nxt = dph_pin ? hwdata[8:0] : pin_r;

    always_comb begin
        hrdata_nxt = 32'h00000000;
        if (haddr[7:0] == AHB_STAT) hrdata_nxt = {23'h000000, busy_r, rdat_r};
        else if (haddr[7:0] == AHB_PIN) hrdata_nxt = {23'h000000, pin_r};
        else if (haddr[7:0] == AHB_CMD) hrdata_nxt = {16'h0000, addr_r, wdata_r};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_wr_r <= 1'b0;
            aph_addr_r <= 8'h00;
            hrdata <= 32'h00000000;
            pin_r <= 9'h000;
        end else begin
            aph_wr_r <= aph && hwrite;
            aph_addr_r <= haddr[7:0];
            hrdata <= (aph && !hwrite) ? hrdata_nxt : hrdata;
            // Holding reset low until clocks settle is software's job
            pin_r <= pin_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            rdat_r <= 8'h00;
        end else begin
            wr_r <= go && hwdata[CMD_WR_BIT];
            rd_r <= go && !hwdata[CMD_WR_BIT];
            if (go) begin
                busy_r <= 1'b1;
                addr_r <= hwdata[15:8];
                wdata_r <= hwdata[7:0];
            end else if (lnk.reg_ack && busy_r) begin
                busy_r <= 1'b0;
                rdat_r <= lnk.reg_rdata;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign lnk.link_rst_n = pin_r[0];
    assign lnk.bitstream_select_pin = pin_r[1];
    assign lnk.frame_clock = pin_r[2];
    assign lnk.bit_clock = pin_r[3];
    assign lnk.audio_data_in = pin_r[4];
    // Straps are only looked at once, when the startup window closes
    assign lnk.strap_pins = pin_r[8:5];
    assign lnk.reg_wr = wr_r;
    assign lnk.reg_rd = rd_r;
    assign lnk.reg_addr = addr_r;
    assign lnk.reg_wdata = wdata_r;
endmodule

// File: bench/dami_link_asserts.sv
// Purpose: Concurrent checks on the link between the source end and the converter end
// Assumes: One clock domain; hresetn is the async active-low reset of both ends
// Notes: Filter readback is modelled by a one-bit shadow of the slow-filter bit
`timescale 1ns/100ps
module dami_link_asserts
    import dami_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic link_rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    logic slow_shadow_r;
    logic slow_shadow_nxt;
    wire link_req = reg_wr || reg_rd;
    wire reference_output_wr = reg_wr && (reg_addr == REG_REFERENCE_OUTPUT);
    wire reference_output_rd = reg_rd && (reg_addr == REG_REFERENCE_OUTPUT);

    // Link reset wipes the device registers, so the shadow follows it
    assign slow_shadow_nxt = !link_rst_n ? REFERENCE_OUTPUT_RST[REFERENCE_OUTPUT_SLOW_BIT] :
        reference_output_wr ? reg_wdata[REFERENCE_OUTPUT_SLOW_BIT] : slow_shadow_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_shadow_r <= REFERENCE_OUTPUT_RST[REFERENCE_OUTPUT_SLOW_BIT];
        end else begin
            slow_shadow_r <= slow_shadow_nxt;
        end
    end

    default clocking dami_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ack_after_wr_a: assert property (reg_wr |=> reg_ack)
        else $error("register write not acknowledged one cycle later");
    ack_after_rd_a: assert property (reg_rd |=> reg_ack)
        else $error("register read not acknowledged one cycle later");
    ack_cause_a: assert property ($rose(reg_ack) |-> $past(link_req))
        else $error("acknowledge without a request");
    ack_single_a: assert property (reg_ack |=> !reg_ack)
        else $error("acknowledge longer than one cycle");
    req_excl_a: assert property (!(reg_wr && reg_rd))
        else $error("read and write requested together");
    req_pulse_a: assert property (link_req |=> !link_req ##1 !link_req)
        else $error("link request repeated before completion");
    rst_no_ack_a: assert property (!link_rst_n |=> !reg_ack)
        else $error("acknowledge while the link is held in reset");
    reference_output_readback_a: assert property (
        reference_output_rd |=> reg_rdata[REFERENCE_OUTPUT_SLOW_BIT] == slow_shadow_r)
        else $error("filter select reads back wrong");
endmodule

// File: bench/dac_audio_input_mode_control_tb.sv
// Purpose: Drives both ends over AHB-Lite and checks startup, mode choice and ratios
// Assumes: Startup window shortened by parameter; straps set through the pin register
// Notes: Frame clock is toggled through the pin register, so ratios are coarse steps
`timescale 1ns/100ps
module dac_audio_input_mode_control_tb;
    import dami_pkg::*;
    localparam int STARTUP_SIM = 200;
    localparam int HALF_T [4] = '{128, 150, 192, 512};
    localparam logic OK_T [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, fmt;
    logic reference_output, port_mode, running, deemphasis_select, slow_filter;
    logic ratio_ok, sample_valid;
    logic signed [23:0] sample_out;
    dami_speed_e speed;
    logic [7:0] b;
    int n_mismatch, n_tests, cnt;

    dami_if dami_if_inst ();
    dami_src dami_src_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lnk(dami_if_inst.src));
    dami_dev #(.STARTUP_CYCLES(STARTUP_SIM)) dami_dev_inst (.hclk(hclk), .hresetn(hresetn),
        .lnk(dami_if_inst.dev), .reference_output(reference_output), .port_mode(port_mode),
        .running(running), .speed_mode_field(speed), .interface_format_field(fmt),
        .deemphasis_select(deemphasis_select), .slow_filter(slow_filter),
        .ratio_ok(ratio_ok), .sample_out(sample_out), .sample_valid(sample_valid));
    dami_link_asserts dami_link_asserts_inst (.hclk(hclk), .hresetn(hresetn),
        .link_rst_n(dami_if_inst.link_rst_n),
        .reg_wr(dami_if_inst.reg_wr), .reg_rd(dami_if_inst.reg_rd),
        .reg_addr(dami_if_inst.reg_addr), .reg_wdata(dami_if_inst.reg_wdata),
        .reg_rdata(dami_if_inst.reg_rdata), .reg_ack(dami_if_inst.reg_ack));

    initial begin
        hclk = 1'h0;
        forever #10 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rdata = hrdata;
    endtask

    // Device access goes through the command word, then busy is polled
    task automatic dev_op(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        logic [31:0] st;
        ahb(1'h1, AHB_CMD, {1'h1, wr, 14'h0, addr, data}, st);
        st = 32'h0000_0100;
        for (int i = 0; i < 20 && st[8] !== 1'h0; i++) ahb(1'h0, AHB_STAT, 32'h0, st);
        check(32'(st[8]), 32'h0);
        rdata = st[7:0];
    endtask

    task automatic pin(input logic [8:0] v);
        ahb(1'h1, AHB_PIN, {23'h0, v}, rd);
    endtask

    // Eight half periods of the frame clock; straps kept at single speed, de-emphasis
    task automatic frames(input int half);
        for (int h = 0; h < 8; h++) begin
            pin({4'h7, 2'h0, h[0], 2'h1});
            repeat (half - 3) @(posedge hclk);
        end
    endtask

    task automatic wait_run(output int n);
        for (n = 0; n < 3000 && running !== 1'h1; n++) @(posedge hclk);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge hclk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (2) @(posedge hclk);
        check({30'h0, reference_output, running}, 32'h0);
        pin(9'h001);
        repeat (100) @(posedge hclk);
        // Window still open: low power but the port answers
        check({30'h0, reference_output, running}, 32'h0);
        dev_op(1'h1, REG_PWR, PORT_EN_VAL, b);
        dev_op(1'h1, REG_REFERENCE_OUTPUT, 8'h20, b);
        dev_op(1'h0, REG_PWR, 8'h00, b);
        check(32'(b), 32'(PORT_EN_VAL));
        check(32'(port_mode), 32'h1);
        wait_run(cnt);
        check({30'h0, reference_output, running}, 32'h3);
        check(32'(slow_filter), 32'h1);
        // Format codes 0 to 5, every speed code, de-emphasis requested each time
        for (int i = 0; i < 6; i++) begin
            dev_op(1'h1, REG_CFG, 8'(i * 16 + 4 + i % 4), b);
            check(32'(fmt), 32'(i));
            check(32'(speed), 32'(i % 4));
            check(32'(deemphasis_select), 32'(i % 4 == 0));
        end
        dev_op(1'h1, REG_REFERENCE_OUTPUT, 8'h00, b);
        check(32'(slow_filter), 32'h0);
        hresetn <= 1'h0;
        @(posedge hclk);
        check({29'h0, reference_output, port_mode, slow_filter}, 32'h0);
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        // Straps 0111: single speed with de-emphasis, right-justified 24-bit
        pin(9'h0E1);
        dev_op(1'h0, REG_REFERENCE_OUTPUT, 8'h00, b);
        check(32'(b), 32'(REFERENCE_OUTPUT_RST));
        wait_run(cnt);
        // Run begins after the window plus the power-up sequence
        check(32'(cnt >= STARTUP_SIM + PWRUP_CYC - 20 && cnt <= STARTUP_SIM + PWRUP_CYC + 10),
              32'h1);
        check(32'(port_mode), 32'h0);
        check({25'h0, slow_filter, deemphasis_select, fmt, speed},
              32'h0000002C);
        pin(9'h0E3);
        repeat (2) @(posedge hclk);
        check(32'(speed), 32'(DAMI_SPD_BITS));
        pin(9'h0E1);
        // Stand-alone single speed: 256 and 384 pass, 300 and 1024 do not
        for (int k = 0; k < 4; k++) begin
            frames(HALF_T[k]);
            check(32'(ratio_ok), 32'(OK_T[k]));
        end
        // One set bit clocked in, then the frame edge hands the word over
        pin(9'h0FD);
        pin(9'h0F5);
        pin(9'h0E1);
        repeat (2) @(posedge hclk);
        check(32'(sample_valid), 32'h1);
        check(32'(sample_out), 32'h00000001);
        dev_op(1'h1, REG_REFERENCE_OUTPUT, 8'h20, b);
        check(32'(slow_filter), 32'h0);
        dev_op(1'h1, REG_PWR, PORT_EN_VAL, b);
        check(32'(port_mode), 32'h1);
        // Enable bit plus divide bit opens the top single-speed ratio
        dev_op(1'h1, REG_PWR, 8'h82, b);
        check(32'(slow_filter), 32'h1);
        frames(512);
        check(32'(ratio_ok), 32'h1);
        print_verdict();
    end
endmodule
